// file: rtl/lfd_top.sv
`include "lfd_defines.svh"

module lfd_top (
  input wire logic CLOCK, // System clock, 125 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic HSEL, // Slave select.
  input wire logic [31:0] HADDR, // Byte address.
  input wire logic [1:0] HTRANS, // Transfer type.
  input wire logic HWRITE, // Write when high.
  input wire logic [2:0] HSIZE, // Transfer size, word only.
  input wire logic [31:0] HWDATA, // Write data.
  input wire logic HREADY, // Bus ready in.
  output logic [31:0] HRDATA, // Read data.
  output logic HREADYOUT, // Slave ready.
  output logic HRESP, // Always OKAY.
  output logic IRQ, // Level interrupt.
  input wire logic GS_CLK_EN, // One-cycle grayscale clock enable.
  input wire logic [15:0] OPEN_CMP, // Open comparator results.
  input wire logic [15:0] SHORT_CMP, // Short comparator results.
  input wire logic [15:0] LEAK_CMP, // Leak comparator results.
  input wire logic [15:0] GS_ZERO, // Channel grayscale value is zero.
  output logic OUTPUTS_OFF, // All channel outputs forced off.
  output logic [15:0] GS_COUNT, // Grayscale counter.
  output logic DETECT_STROBE, // Open/short capture pulse.
  output logic LEAK_STROBE, // Leak capture pulse.
  output logic SINK_ENABLE, // Invisible check test sink on.
  output logic [1:0] SINK_CURRENT_SEL, // Test sink current select.
  output logic SOURCE_ENABLE, // Leak test source on.
  output logic [1:0] OPEN_THRESHOLD_SEL, // Open comparator threshold.
  output logic [1:0] SHORT_THRESHOLD_SEL, // Short comparator threshold.
  output logic [2:0] POWER_SAVE_SEL // Power-save mode select.
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] latch_count(input logic [1:0] sel);
    case (sel)
      2'h0: latch_count = `LFD_LATCH_CNT_0;
      2'h1: latch_count = `LFD_LATCH_CNT_1;
      2'h2: latch_count = `LFD_LATCH_CNT_2;
      default: latch_count = `LFD_LATCH_CNT_3;
    endcase
  endfunction

  function automatic logic [31:0] ctrl_word(input lfd_pkg::lfd_state_s s);
    ctrl_word = 32'h0000_0000;
    ctrl_word[`LFD_CTRL_BLANK] = s.blank;
    ctrl_word[`LFD_CTRL_AUTO_RPT] = s.auto_display_repeat;
    ctrl_word[`LFD_CTRL_TMG_RST] = s.display_timing_reset;
    ctrl_word[`LFD_CTRL_INV_EN] = s.invisible_check_enable;
    ctrl_word[`LFD_CTRL_INV_RPT] = s.invisible_check_repeat;
    ctrl_word[`LFD_CTRL_INV_CUR_HI:`LFD_CTRL_INV_CUR_LO] = s.invisible_check_current_sel;
    ctrl_word[`LFD_CTRL_LEAK_EN] = s.leak_check_enable;
    ctrl_word[`LFD_CTRL_PSAVE_HI:`LFD_CTRL_PSAVE_LO] = s.power_save_select;
    ctrl_word[`LFD_CTRL_OPEN_HI:`LFD_CTRL_OPEN_LO] = s.open_threshold_sel;
    ctrl_word[`LFD_CTRL_SHORT_HI:`LFD_CTRL_SHORT_LO] = s.short_threshold_sel;
    ctrl_word[`LFD_CTRL_LATCH_HI:`LFD_CTRL_LATCH_LO] = s.result_latch_timing;
  endfunction

  lfd_pkg::lfd_state_s state_reg;
  lfd_pkg::lfd_state_s state_next;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic gs_load;
    logic blank_fall;
    logic restart;
    logic wrap;
    logic arm;
    logic leak_active;
    logic [2:0] irq_clear;
    logic [2:0] irq_event;
    gs_load = 1'b0;
    blank_fall = 1'b0;
    restart = 1'b0;
    wrap = 1'b0;
    arm = 1'b0;
    leak_active = 1'b0;
    irq_clear = 3'h0;
    irq_event = 3'h0;
    state_next = state_reg;
    state_next.detect_strobe = 1'b0;
    state_next.leak_strobe = 1'b0;
    state_next.hready = 1'b1;

    // Bus slave: one wait cycle so that read data come from a flip-flop.
    if (state_reg.dp_active) begin
      state_next.dp_active = 1'b0;
      state_next.hrdata = 32'h0000_0000;
      if (state_reg.dp_write) begin
        case (state_reg.dp_addr)
          `LFD_OFF_CTRL: begin
            state_next.blank = HWDATA[`LFD_CTRL_BLANK];
            state_next.auto_display_repeat = HWDATA[`LFD_CTRL_AUTO_RPT];
            state_next.display_timing_reset = HWDATA[`LFD_CTRL_TMG_RST];
            state_next.invisible_check_enable = HWDATA[`LFD_CTRL_INV_EN];
            state_next.invisible_check_repeat = HWDATA[`LFD_CTRL_INV_RPT];
            state_next.invisible_check_current_sel =
              HWDATA[`LFD_CTRL_INV_CUR_HI:`LFD_CTRL_INV_CUR_LO];
            state_next.leak_check_enable = HWDATA[`LFD_CTRL_LEAK_EN];
            state_next.power_save_select = HWDATA[`LFD_CTRL_PSAVE_HI:`LFD_CTRL_PSAVE_LO];
            state_next.open_threshold_sel = HWDATA[`LFD_CTRL_OPEN_HI:`LFD_CTRL_OPEN_LO];
            state_next.short_threshold_sel = HWDATA[`LFD_CTRL_SHORT_HI:`LFD_CTRL_SHORT_LO];
            state_next.result_latch_timing = HWDATA[`LFD_CTRL_LATCH_HI:`LFD_CTRL_LATCH_LO];
          end
          `LFD_OFF_CMD: begin
            gs_load = HWDATA[`LFD_CMD_GS_LOAD];
          end
          `LFD_OFF_IRQ_STATUS: begin
            irq_clear = HWDATA[2:0];
          end
          `LFD_OFF_IRQ_MASK: begin
            state_next.irq_mask = HWDATA[2:0];
          end
          default: begin
          end
        endcase
      end else begin
        case (state_reg.dp_addr)
          `LFD_OFF_CTRL: state_next.hrdata = ctrl_word(state_reg);
          `LFD_OFF_DETECT: state_next.hrdata = {state_reg.shorted_led_flag,
                                                state_reg.open_led_flag};
          `LFD_OFF_LEAK: state_next.hrdata = {16'h0000, state_reg.leak_flag};
          `LFD_OFF_IRQ_STATUS: state_next.hrdata = {29'h0, state_reg.irq_status};
          `LFD_OFF_IRQ_MASK: state_next.hrdata = {29'h0, state_reg.irq_mask};
          `LFD_OFF_COUNT: state_next.hrdata = {15'h0, state_reg.running,
                                               state_reg.gs_count};
          default: state_next.hrdata = 32'h0000_0000;
        endcase
      end
    end else if (HSEL && HTRANS[1] && HREADY) begin
      state_next.dp_active = 1'b1;
      state_next.dp_write = HWRITE;
      state_next.dp_addr = HADDR[7:0];
      state_next.hready = 1'b0;
    end

    // Display timing.
    blank_fall = state_reg.blank && !state_next.blank;
    restart = blank_fall || (gs_load && state_next.display_timing_reset);
    if (state_next.blank) begin
      state_next.gs_count = 16'h0000;
      state_next.running = 1'b0;
    end else if (restart) begin
      state_next.gs_count = 16'h0000;
      state_next.running = 1'b1;
    end else if (state_reg.running && GS_CLK_EN) begin
      if (state_reg.gs_count == `LFD_GS_LAST) begin
        wrap = 1'b1;
        state_next.leak_strobe = 1'b1;
        leak_active = state_reg.leak_check_enable && !state_reg.invisible_check_enable;
        if (leak_active) begin
          state_next.leak_flag = LEAK_CMP & GS_ZERO;
        end
        state_next.gs_count = 16'h0000;
        state_next.running = state_reg.auto_display_repeat;
      end else begin
        state_next.gs_count = state_reg.gs_count + 16'h0001;
      end
      // Counter reaches the selected count on this grayscale edge.
      if (state_reg.armed && state_reg.gs_count + 16'h0001 ==
          latch_count(state_reg.result_latch_timing)) begin
        state_next.detect_strobe = 1'b1;
        state_next.open_led_flag = OPEN_CMP;
        state_next.shorted_led_flag = SHORT_CMP;
        state_next.armed = 1'b0;
      end
    end

    // Only the power-up arming survives when the invisible check is off.
    arm = state_next.invisible_check_enable && (restart ||
          (gs_load && state_next.auto_display_repeat &&
           !state_next.invisible_check_repeat) ||
          (wrap && state_reg.auto_display_repeat && state_reg.invisible_check_repeat));
    if (arm) begin
      state_next.armed = 1'b1;
    end

    // Clearing the flags at once, not at the next capture, keeps stale leak results
    // from being read after the check was switched off.
    if (!state_next.leak_check_enable || state_next.invisible_check_enable) begin
      state_next.leak_flag = 16'h0000;
    end

    state_next.sink_enable = state_next.invisible_check_enable &&
                             state_next.armed && state_next.running;
    state_next.source_enable = state_next.leak_check_enable &&
                               !state_next.invisible_check_enable &&
                               state_next.running;
    state_next.outputs_off = state_next.blank || !state_next.running;

    // Interrupts: a new event wins over a simultaneous clear.
    irq_event[`LFD_IRQ_DETECT] = state_next.detect_strobe;
    irq_event[`LFD_IRQ_LEAK] = state_next.leak_strobe && leak_active;
    irq_event[`LFD_IRQ_PERIOD] = wrap;
    state_next.irq_status = (state_reg.irq_status & ~irq_clear) | irq_event;
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      // Fields that power up undefined start at zero, so no test current flows
      // before the controller has programmed them; the power-up arm still stands.
      state_reg <= '0;
      state_reg.blank <= `LFD_RST_BLANK;
      state_reg.power_save_select <= `LFD_RST_PSAVE;
      state_reg.armed <= `LFD_RST_ARMED;
      state_reg.outputs_off <= 1'b1;
      state_reg.hready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The threshold and current selects drive analog trims directly.
  assign HRDATA = state_reg.hrdata;
  assign HREADYOUT = state_reg.hready;
  assign HRESP = 1'b0;
  assign IRQ = state_reg.irq;
  assign OUTPUTS_OFF = state_reg.outputs_off;
  assign GS_COUNT = state_reg.gs_count;
  assign DETECT_STROBE = state_reg.detect_strobe;
  assign LEAK_STROBE = state_reg.leak_strobe;
  assign SINK_ENABLE = state_reg.sink_enable;
  assign SINK_CURRENT_SEL = state_reg.invisible_check_current_sel;
  assign SOURCE_ENABLE = state_reg.source_enable;
  assign OPEN_THRESHOLD_SEL = state_reg.open_threshold_sel;
  assign SHORT_THRESHOLD_SEL = state_reg.short_threshold_sel;
  assign POWER_SAVE_SEL = state_reg.power_save_select;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_BLANK_HOLDS: assert property (@(posedge CLOCK) disable iff (RST)
    state_reg.blank |-> (GS_COUNT == 16'h0000) && OUTPUTS_OFF && !SINK_ENABLE)
    else $error("Blank did not hold counter and outputs.");

  AST_STROBE_AT_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
    DETECT_STROBE |-> GS_COUNT == latch_count($past(state_reg.result_latch_timing)))
    else $error("Detect strobe at wrong grayscale count.");

  AST_STROBE_ONE_SHOT: assert property (@(posedge CLOCK) disable iff (RST)
    DETECT_STROBE |=> !DETECT_STROBE)
    else $error("Detect strobe longer than one cycle.");

  AST_STROBE_CAPTURES: assert property (@(posedge CLOCK) disable iff (RST)
    DETECT_STROBE |-> (state_reg.open_led_flag == $past(OPEN_CMP)) &&
      (state_reg.shorted_led_flag == $past(SHORT_CMP)) && $past(state_reg.armed))
    else $error("Detect strobe without arm or capture.");

  AST_INV_OFF: assert property (@(posedge CLOCK) disable iff (RST)
    SINK_ENABLE |-> state_reg.invisible_check_enable && state_reg.running)
    else $error("Test sink on while invisible check disabled.");

  AST_LEAK_BLOCKED: assert property (@(posedge CLOCK) disable iff (RST)
    state_reg.invisible_check_enable |-> !SOURCE_ENABLE && (state_reg.leak_flag == 16'h0000))
    else $error("Leak check active with invisible check on.");

  AST_LEAK_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
    !state_reg.leak_check_enable |-> state_reg.leak_flag == 16'h0000)
    else $error("Leak flags set while leak check disabled.");

  AST_LEAK_AT_END: assert property (@(posedge CLOCK) disable iff (RST)
    ($changed(state_reg.leak_flag) && state_reg.leak_check_enable &&
     $past(state_reg.leak_check_enable) && !state_reg.invisible_check_enable &&
     !$past(state_reg.invisible_check_enable)) |-> LEAK_STROBE && $past(GS_COUNT) == 16'hffff)
    else $error("Leak flags changed away from count 65535.");

  AST_LEAK_ONLY_ZERO_GS: assert property (@(posedge CLOCK) disable iff (RST)
    (LEAK_STROBE && state_reg.leak_check_enable) |->
      (state_reg.leak_flag & ~$past(GS_ZERO)) == 16'h0000)
    else $error("Leak flag set on nonzero grayscale output.");

  AST_PERIOD_WRAP: assert property (@(posedge CLOCK) disable iff (RST)
    (state_reg.running && GS_CLK_EN && GS_COUNT == 16'hffff && !state_next.blank &&
     !state_next.dp_active && !state_reg.dp_active) |=>
      (GS_COUNT == 16'h0000) && (state_reg.running == $past(state_reg.auto_display_repeat)))
    else $error("Display period did not wrap correctly.");

  AST_REPEAT_REARM: assert property (@(posedge CLOCK) disable iff (RST)
    (state_reg.running && GS_CLK_EN && GS_COUNT == 16'hffff && !state_reg.dp_active &&
     state_reg.auto_display_repeat && state_reg.invisible_check_enable &&
     state_reg.invisible_check_repeat) |=> state_reg.armed)
    else $error("Invisible check not rearmed for next period.");

  // ----------------------------------------------------------------------
  // Counter checks
  // ----------------------------------------------------------------------
  // Bus transfers are kept out of the step and hold antecedents, since a write may restart the count.
  AST_COUNT_STEP: assert property (@(posedge CLOCK) disable iff (RST)
    (state_reg.running && GS_CLK_EN && !state_reg.dp_active && GS_COUNT != 16'hffff) |=>
      GS_COUNT == $past(GS_COUNT) + 16'h0001)
    else $error("Grayscale counter did not step by one.");

  AST_IDLE_HOLDS: assert property (@(posedge CLOCK) disable iff (RST)
    (!state_reg.running && !state_reg.dp_active) |=> GS_COUNT == $past(GS_COUNT))
    else $error("Grayscale counter moved while stopped.");

  AST_RUN_NEEDS_UNBLANK: assert property (@(posedge CLOCK) disable iff (RST)
    state_reg.running |-> !state_reg.blank)
    else $error("Counter running while blanked.");

  AST_RESTART_CLEARS: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(state_reg.blank) |-> (GS_COUNT == 16'h0000) && state_reg.running)
    else $error("Blank release did not restart the counter.");

  // ----------------------------------------------------------------------
  // Leak checks
  // ----------------------------------------------------------------------
  AST_LEAK_STROBE_AT_WRAP: assert property (@(posedge CLOCK) disable iff (RST)
    LEAK_STROBE |-> (GS_COUNT == 16'h0000) && ($past(GS_COUNT) == 16'hffff))
    else $error("Leak strobe away from the period end.");

  AST_LEAK_STROBE_ONE_SHOT: assert property (@(posedge CLOCK) disable iff (RST)
    LEAK_STROBE |=> !LEAK_STROBE)
    else $error("Leak strobe longer than one cycle.");

  AST_SOURCE_GATED: assert property (@(posedge CLOCK) disable iff (RST)
    SOURCE_ENABLE |-> state_reg.leak_check_enable && !state_reg.invisible_check_enable &&
      state_reg.running)
    else $error("Leak source on outside an enabled leak check.");

  // ----------------------------------------------------------------------
  // Arming checks
  // ----------------------------------------------------------------------
  // Only the power-up arm may exist without the enable; every later arm needs it,
  // and a capture always needs an arm.
  AST_ARM_NEEDS_ENABLE: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(state_reg.armed) |-> state_reg.invisible_check_enable)
    else $error("Check armed while invisible check disabled.");

  AST_NO_CAPTURE_UNARMED: assert property (@(posedge CLOCK) disable iff (RST)
    !state_reg.armed |=> !DETECT_STROBE)
    else $error("Detect strobe without a pending arm.");

  AST_SINK_ARMED: assert property (@(posedge CLOCK) disable iff (RST)
    SINK_ENABLE |-> state_reg.armed)
    else $error("Test sink on without a pending check.");

  AST_DETECT_NEEDS_RUN: assert property (@(posedge CLOCK) disable iff (RST)
    DETECT_STROBE |-> $past(state_reg.running) && $past(GS_CLK_EN))
    else $error("Detect strobe without a grayscale edge.");

  AST_NO_REARM_AT_WRAP: assert property (@(posedge CLOCK) disable iff (RST)
    (state_reg.running && GS_CLK_EN && GS_COUNT == 16'hffff && !state_reg.dp_active &&
     !state_reg.invisible_check_repeat && !state_reg.armed) |=> !state_reg.armed)
    else $error("Check rearmed at wrap without repeat.");

endmodule // lfd_top

// file: rtl/lfd_defines.svh
`ifndef LFD_DEFINES_SVH
`define LFD_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LFD_OFF_CTRL 8'h00
`define LFD_OFF_CMD 8'h04
`define LFD_OFF_DETECT 8'h08
`define LFD_OFF_LEAK 8'h0c
`define LFD_OFF_IRQ_STATUS 8'h10
`define LFD_OFF_IRQ_MASK 8'h14
`define LFD_OFF_COUNT 8'h18

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define LFD_CTRL_BLANK 0
`define LFD_CTRL_AUTO_RPT 1
`define LFD_CTRL_TMG_RST 2
`define LFD_CTRL_INV_EN 3
`define LFD_CTRL_INV_RPT 4
`define LFD_CTRL_INV_CUR_LO 5
`define LFD_CTRL_INV_CUR_HI 6
`define LFD_CTRL_LEAK_EN 7
`define LFD_CTRL_PSAVE_LO 8
`define LFD_CTRL_PSAVE_HI 10
`define LFD_CTRL_OPEN_LO 11
`define LFD_CTRL_OPEN_HI 12
`define LFD_CTRL_SHORT_LO 13
`define LFD_CTRL_SHORT_HI 14
`define LFD_CTRL_LATCH_LO 15
`define LFD_CTRL_LATCH_HI 16
`define LFD_CMD_GS_LOAD 0

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define LFD_IRQ_DETECT 0
`define LFD_IRQ_LEAK 1
`define LFD_IRQ_PERIOD 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LFD_RST_BLANK 1'h1
`define LFD_RST_PSAVE 3'h7
`define LFD_RST_ARMED 1'h1

// ----------------------------------------------------------------------
// Grayscale clock counts
// ----------------------------------------------------------------------
`define LFD_GS_LAST 16'hffff
`define LFD_LATCH_CNT_0 16'h0011
`define LFD_LATCH_CNT_1 16'h0021
`define LFD_LATCH_CNT_2 16'h0041
`define LFD_LATCH_CNT_3 16'h0081

`endif

// file: rtl/lfd_pkg.sv
package lfd_pkg;

  typedef struct packed {
    logic blank;
    logic auto_display_repeat;
    logic display_timing_reset;
    logic invisible_check_enable;
    logic invisible_check_repeat;
    logic [1:0] invisible_check_current_sel;
    logic leak_check_enable;
    logic [2:0] power_save_select;
    logic [1:0] open_threshold_sel;
    logic [1:0] short_threshold_sel;
    logic [1:0] result_latch_timing;
    logic [15:0] gs_count;
    logic running;
    logic armed;
    logic [15:0] open_led_flag;
    logic [15:0] shorted_led_flag;
    logic [15:0] leak_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic irq;
    logic detect_strobe;
    logic leak_strobe;
    logic sink_enable;
    logic source_enable;
    logic outputs_off;
    logic dp_active;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hready;
  } lfd_state_s;

endpackage

// file: tb/lfd_link_model.sv
module lfd_link_model (
  input wire logic clock, // System clock.
  input wire logic rst, // Reset, active high.
  input wire logic run, // Grayscale clock allowed.
  input wire logic fast, // Pulse every cycle instead of every other.
  input wire logic [31:0] pat, // Pattern for the comparator lines.
  output logic gs_clk_en, // Grayscale clock enable pulse.
  output logic [15:0] open_cmp, // Open comparator levels.
  output logic [15:0] short_cmp, // Short comparator levels.
  output logic [15:0] leak_cmp, // Leak comparator levels.
  output logic [15:0] gs_zero // Zero grayscale levels.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Grayscale clock and comparator lines
  // ----------------------------------------------------------------------
  // Comparator lines change every cycle, so a capture on the wrong edge shows.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gs_clk_en <= 1'b0;
      open_cmp <= 16'h0000;
      short_cmp <= 16'h0000;
      leak_cmp <= 16'h0000;
      gs_zero <= 16'h0000;
    end else begin
      gs_clk_en <= run & (fast | ~gs_clk_en);
      open_cmp <= pat[15:0];
      short_cmp <= pat[31:16];
      leak_cmp <= ~pat[15:0];
      gs_zero <= pat[31:16];
    end
  end
endmodule // lfd_link_model

// file: tb/tb_top.sv
`include "lfd_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic CLOCK = 1'b0;
  logic RST, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, GS_CLK_EN, OUTPUTS_OFF;
  logic DETECT_STROBE, LEAK_STROBE, SINK_ENABLE, SOURCE_ENABLE;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS, SINK_CURRENT_SEL, OPEN_THRESHOLD_SEL, SHORT_THRESHOLD_SEL;
  logic [2:0] HSIZE, POWER_SAVE_SEL;
  logic [15:0] OPEN_CMP, SHORT_CMP, LEAK_CMP, GS_ZERO, GS_COUNT;
  logic run, fast;
  logic [31:0] rnd = 32'ha1cd;
  logic [31:0] exp_det, exp_leak, det_d, leak_d, r, d;
  int num_errors = 0;
  int checked = 0;
  int nstrobe = 0;
  int lat_cnt[4] = '{17, 33, 65, 129};

  always #4 CLOCK = ~CLOCK;

  lfd_top uut (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .GS_CLK_EN(GS_CLK_EN),
    .OPEN_CMP(OPEN_CMP), .SHORT_CMP(SHORT_CMP), .LEAK_CMP(LEAK_CMP), .GS_ZERO(GS_ZERO),
    .OUTPUTS_OFF(OUTPUTS_OFF), .GS_COUNT(GS_COUNT), .DETECT_STROBE(DETECT_STROBE),
    .LEAK_STROBE(LEAK_STROBE), .SINK_ENABLE(SINK_ENABLE), .SINK_CURRENT_SEL(SINK_CURRENT_SEL),
    .SOURCE_ENABLE(SOURCE_ENABLE), .OPEN_THRESHOLD_SEL(OPEN_THRESHOLD_SEL),
    .SHORT_THRESHOLD_SEL(SHORT_THRESHOLD_SEL), .POWER_SAVE_SEL(POWER_SAVE_SEL));

  lfd_link_model link (.clock(CLOCK), .rst(RST), .run(run), .fast(fast), .pat(rnd),
    .gs_clk_en(GS_CLK_EN), .open_cmp(OPEN_CMP), .short_cmp(SHORT_CMP),
    .leak_cmp(LEAK_CMP), .gs_zero(GS_ZERO));

  // ----------------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Captured flags equal the comparator lines seen at the edge before the strobe.
  always @(posedge CLOCK) begin
    if (DETECT_STROBE === 1'b1) begin
      exp_det = det_d;
      nstrobe++;
    end
    if (LEAK_STROBE === 1'b1) exp_leak = leak_d;
    det_d = {SHORT_CMP, OPEN_CMP};
    leak_d = {16'h0000, LEAK_CMP & GS_ZERO};
    rnd <= lfsr(rnd);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h000000, a};
    HWRITE <= w;
    do begin @(posedge CLOCK); n++; end while (HREADYOUT !== 1'b1 && n < 20);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do begin @(posedge CLOCK); n++; end while (HREADYOUT !== 1'b1 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1, "bus answer missing");
    rd = HRDATA;
    chk(32'(HRESP), 32'h0, "bus response");
  endtask

  task automatic wait_for(input int which, input int limit);
    int n;
    n = 0;
    while (((which == 0) ? DETECT_STROBE : LEAK_STROBE) !== 1'b1 && n < limit) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= limit) chk(32'h0, 32'h1, "strobe missing");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge CLOCK);
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    RST = 1'b1; HSEL = 1'b0; HADDR = 32'h0; HTRANS = 2'h0; HWRITE = 1'b0;
    HSIZE = 3'h2; HWDATA = 32'h0; run = 1'b0; fast = 1'b0;
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    bus(1'b0, `LFD_OFF_CTRL, 32'h0, r);
    chk(r, 32'h701, "control after reset");
    chk(32'(POWER_SAVE_SEL), 32'h7, "power save after reset");
    chk(32'(OUTPUTS_OFF), 32'h1, "outputs off after reset");
    bus(1'b0, 8'h1c, 32'h0, r);
    chk(r, 32'h0, "unmapped read");
    bus(1'b1, `LFD_OFF_IRQ_MASK, 32'h1, r);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      d = (rnd & 32'h7f60) | 32'h89 | (32'(k) << 15);
      bus(1'b1, `LFD_OFF_CTRL, d, r);
      bus(1'b0, `LFD_OFF_CTRL, 32'h0, r);
      chk(r, d, "control readback");
      chk(32'(SINK_CURRENT_SEL), 32'(d[6:5]), "sink current");
      chk(32'(OPEN_THRESHOLD_SEL), 32'(d[12:11]), "open threshold");
      chk(32'(SHORT_THRESHOLD_SEL), 32'(d[14:13]), "short threshold");
      chk(32'(POWER_SAVE_SEL), 32'(d[10:8]), "power save");
      run <= 1'b1;
      bus(1'b1, `LFD_OFF_CTRL, d & 32'hfffffffe, r);
      repeat (2) @(posedge CLOCK);
      chk(32'(SINK_ENABLE), 32'h1, "test sink on");
      chk(32'(SOURCE_ENABLE), 32'h0, "leak source off");
      chk(32'(OUTPUTS_OFF), 32'h0, "outputs released");
      wait_for(0, 400);
      chk(32'(GS_COUNT), lat_cnt[k], "latch count");
      chk(32'(SINK_ENABLE), 32'h0, "sink off after capture");
      @(posedge CLOCK);
      chk(32'(DETECT_STROBE), 32'h0, "strobe one cycle");
      bus(1'b0, `LFD_OFF_DETECT, 32'h0, r);
      chk(r, exp_det, "detect flags");
      chk(32'(IRQ), 32'h1, "interrupt raised");
      bus(1'b1, `LFD_OFF_IRQ_STATUS, 32'h1, r);
      repeat (2) @(posedge CLOCK);
      chk(32'(IRQ), 32'h0, "interrupt cleared");
      run <= 1'b0;
      $display("latch timing %0d test done", k);
    end
    d = 32'(nstrobe);
    run <= 1'b1;
    bus(1'b1, `LFD_OFF_CTRL, 32'h11, r);
    bus(1'b1, `LFD_OFF_CTRL, 32'h10, r);
    repeat (300) @(posedge CLOCK);
    chk(32'(nstrobe), d, "no capture when disabled");
    chk(32'(SINK_ENABLE), 32'h0, "sink stays off");
    $display("disabled check test done");
    bus(1'b1, `LFD_OFF_CTRL, 32'hc, r);
    bus(1'b1, `LFD_OFF_CMD, 32'h1, r);
    wait_for(0, 400);
    chk(32'(GS_COUNT), lat_cnt[0], "capture after load restart");
    bus(1'b1, `LFD_OFF_CTRL, 32'ha, r);
    chk(32'(SINK_ENABLE), 32'h0, "no arm without load");
    bus(1'b1, `LFD_OFF_CMD, 32'h1, r);
    repeat (2) @(posedge CLOCK);
    chk(32'(SINK_ENABLE), 32'h1, "armed by new load");
    bus(1'b1, `LFD_OFF_CTRL, 32'he, r);
    bus(1'b1, `LFD_OFF_CMD, 32'h1, r);
    wait_for(0, 400);
    chk(32'(GS_COUNT), lat_cnt[0], "capture after second load");
    bus(1'b1, `LFD_OFF_IRQ_STATUS, 32'h1, r);
    $display("load test done");
    bus(1'b1, `LFD_OFF_CTRL, 32'h81, r);
    fast <= 1'b1;
    bus(1'b1, `LFD_OFF_CTRL, 32'h80, r);
    repeat (2) @(posedge CLOCK);
    chk(32'(SOURCE_ENABLE), 32'h1, "leak source on");
    wait_for(1, 70000);
    bus(1'b0, `LFD_OFF_LEAK, 32'h0, r);
    chk(r, exp_leak, "leak flags");
    chk(32'(OUTPUTS_OFF), 32'h1, "single period ends");
    bus(1'b0, `LFD_OFF_IRQ_STATUS, 32'h0, r);
    chk(r & 32'h6, 32'h6, "leak and period events");
    chk(32'(IRQ), 32'h0, "masked events stay quiet");
    $display("leak test done");
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    chk(32'(POWER_SAVE_SEL), 32'h7, "power save after second reset");
    bus(1'b1, `LFD_OFF_CTRL, 32'h0, r);
    wait_for(0, 400);
    chk(32'(GS_COUNT), lat_cnt[0], "power-up capture with check off");
    bus(1'b0, `LFD_OFF_DETECT, 32'h0, r);
    chk(r, exp_det, "power-up detect flags");
    $display("second reset test done");
    end_of_test();
  end
endmodule // tb_top
